// >>> inc/viu_pkg.sv
// Constants and types shared by the vectored interrupt unit
package viu_pkg;

	// ---------------------------------------------------------------
	// Data space map
	// ---------------------------------------------------------------
	localparam logic [7:0]  OPT_ADDR       = 8'hc8; // interrupt_option
	localparam logic [7:0]  OPT_RESET      = 8'h00;

	// ---------------------------------------------------------------
	// Option register fields
	// ---------------------------------------------------------------
	localparam int          GLB_EN_BIT     = 4; // global_irq_enable
	localparam int          EDGE2_BIT      = 5; // input2_edge_select
	localparam int          LEVEL1_BIT     = 6; // input1_level_select

	// ---------------------------------------------------------------
	// Vector addresses (lower byte of each pair)
	// ---------------------------------------------------------------
	localparam logic [11:0] VEC0_NMI       = 12'hffc;
	localparam logic [11:0] VEC1_PORTA     = 12'hff6;
	localparam logic [11:0] VEC2_PORTBC    = 12'hff4;
	localparam logic [11:0] VEC3_TIMER     = 12'hff2;
	localparam logic [11:0] VEC4_ADC       = 12'hff0;

	// ---------------------------------------------------------------
	// Return stack and source count
	// ---------------------------------------------------------------
	localparam int          STACK_DEPTH    = 6;
	localparam int          PC_W           = 12;
	localparam int          NUM_MASKABLE   = 4;
	localparam logic [2:0]  STACK_EMPTY    = 3'h0;
	localparam logic [2:0]  STACK_FULL     = 3'h6;

	// ---------------------------------------------------------------
	// Flag-pair mode
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_IRQ,
		MODE_NMI
	} viu_mode_t;

endpackage

// >>> logic/viu_core.sv
// Vectored interrupt unit: latching, priority, vectoring, return stack
`timescale 1ns/1ns

module viu_core
	import viu_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  srst,
	// Data space write port
	input  wire logic [7:0]            ds_addr,
	input  wire logic [7:0]            ds_wdata,
	input  wire logic                  ds_wr,
	input  wire logic                  ds_bitop,
	// External interrupt pins, asynchronous
	input  wire logic                  nmi_pin_n,
	input  wire logic                  porta_irq_n,
	input  wire logic                  portbc_irq,
	// Peripheral request flags and masks
	input  wire logic                  timer_zero_flag,
	input  wire logic                  timer_irq_mask,
	input  wire logic                  converter_done_flag,
	input  wire logic                  converter_irq_mask,
	// Core sequencing
	input  wire logic                  instr_end,
	input  wire logic                  return_from_irq,
	input  wire logic                  sub_call,
	input  wire logic                  sub_return,
	input  wire logic [viu_pkg::PC_W-1:0] next_pc,
	// Answers to the core
	output logic                       irq_take,
	output logic [viu_pkg::PC_W-1:0]   vector_addr,
	output logic                       ret_valid,
	output logic [viu_pkg::PC_W-1:0]   ret_addr,
	output viu_pkg::viu_mode_t         flag_mode,
	output logic [7:0]                 option_view
);
	import viu_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	logic [2:0] pin_last;
	logic       nmi_fall;
	logic       pa_fall;
	logic       pbc_edge;

	// Two synchroniser stages and a delayed copy for edges; the first stage is never looked at
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_meta <= 3'h7;
			pin_sync <= 3'h7;
			pin_last <= 3'h7;
		end else begin
			pin_meta <= {portbc_irq, porta_irq_n, nmi_pin_n};
			pin_sync <= pin_meta;
			pin_last <= pin_sync;
		end
	end

	// Edge detectors on the synchronised levels
	assign nmi_fall = pin_last[0] & ~pin_sync[0];
	assign pa_fall  = pin_last[1] & ~pin_sync[1];
	assign pbc_edge = option_view[EDGE2_BIT] ?
		(~pin_last[2] & pin_sync[2]) : (pin_last[2] & ~pin_sync[2]);

	// ---------------------------------------------------------------
	// Option register
	// ---------------------------------------------------------------
	// whole-byte writes only; no data space read path, the core sees it on option_view
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			option_view <= OPT_RESET;
		end else if (ds_wr && !ds_bitop && ds_addr == OPT_ADDR) begin
			// mode bits 5 and 6 plus global enable
			option_view <= ds_wdata;
		end
	end

	// ---------------------------------------------------------------
	// Request latches and sources
	// ---------------------------------------------------------------
	logic                    nmi_latch;
	logic                    pa_latch;
	logic                    pbc_latch;
	logic [NUM_MASKABLE-1:0] req;
	logic                    take_nmi;
	logic                    take_mask;
	logic [1:0]              take_idx;
	viu_mode_t               mode;
	viu_mode_t               mode_before_nmi;
	logic                    level_mode;

	assign level_mode = option_view[LEVEL1_BIT];

	// falling edge latch, cleared on routine entry
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			nmi_latch <= 1'b0;
		end else if (nmi_fall) begin
			// New edge wins over the entry clear
			nmi_latch <= 1'b1;
		end else if (take_nmi) begin
			nmi_latch <= 1'b0;
		end
	end

	// one stored request; later edges merge into it
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pa_latch <= 1'b0;
		end else if (level_mode) begin
			// nothing is stored in level mode
			pa_latch <= 1'b0;
		end else if (pa_fall) begin
			pa_latch <= 1'b1;
		end else if (take_mask && take_idx == 2'd0) begin
			pa_latch <= 1'b0;
		end
	end

	// same storage for the shared port B/C input
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pbc_latch <= 1'b0;
		end else if (pbc_edge) begin
			pbc_latch <= 1'b1;
		end else if (take_mask && take_idx == 2'd1) begin
			pbc_latch <= 1'b0;
		end
	end

	always_comb begin
		// low level or stored falling edge
		req[0] = level_mode ? ~pin_sync[1] : pa_latch;
		req[1] = pbc_latch;
		// flag passes only with its mask set
		req[2] = timer_zero_flag & timer_irq_mask;
		req[3] = converter_done_flag & converter_irq_mask;
	end

	// ---------------------------------------------------------------
	// Arbitration at the instruction boundary
	// ---------------------------------------------------------------
	// sampled only when an instruction ends
	// non-maskable enters unless already in its own routine
	assign take_nmi  = instr_end && nmi_latch && mode != MODE_NMI;
	// maskable only from normal mode with global enable
	assign take_mask = instr_end && !take_nmi && mode == MODE_NORMAL &&
		option_view[GLB_EN_BIT] && (|req);

	always_comb begin
		take_idx = 2'd3;
		for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
			if (req[i]) begin
				take_idx = 2'(i);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_take    <= 1'b0;
			vector_addr <= VEC0_NMI;
		end else begin
			irq_take <= take_nmi | take_mask;
			if (take_nmi) begin
				vector_addr <= VEC0_NMI;
			end else if (take_mask) begin
				unique case (take_idx)
					2'd0: vector_addr <= VEC1_PORTA;
					2'd1: vector_addr <= VEC2_PORTBC;
					2'd2: vector_addr <= VEC3_TIMER;
					2'd3: vector_addr <= VEC4_ADC;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Flag-pair mode
	// ---------------------------------------------------------------
	// start in non-maskable mode, switch on entry and return
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mode            <= MODE_NMI;
			mode_before_nmi <= MODE_NORMAL;
		end else if (take_nmi) begin
			mode_before_nmi <= mode;
			mode            <= MODE_NMI;
		end else if (take_mask) begin
			mode <= MODE_IRQ;
		end else if (return_from_irq) begin
			// routine over; back to the mode held before the non-maskable entry, else normal
			mode <= (mode == MODE_NMI) ? mode_before_nmi : MODE_NORMAL;
		end
	end

	assign flag_mode = mode;

	// ---------------------------------------------------------------
	// Return stack
	// ---------------------------------------------------------------
	logic [PC_W-1:0] stack_mem [STACK_DEPTH];
	logic [2:0]      stack_fill;
	logic            push;
	logic            pop;

	assign push = take_nmi | take_mask | sub_call;
	assign pop  = (return_from_irq | sub_return) & ~push;

	// shift in on push, oldest level falls off the end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_mem[i] <= '0;
			end
		end else if (push) begin
			stack_mem[0] <= next_pc;
			for (int i = 1; i < STACK_DEPTH; i++) begin
				stack_mem[i] <= stack_mem[i-1];
			end
		end else if (pop && stack_fill != STACK_EMPTY) begin
			for (int i = 0; i < STACK_DEPTH - 1; i++) begin
				stack_mem[i] <= stack_mem[i+1];
			end
		end
	end

	// Fill level saturates at both ends
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stack_fill <= STACK_EMPTY;
		end else if (push && stack_fill != STACK_FULL) begin
			stack_fill <= stack_fill + 3'h1;
		end else if (pop && stack_fill != STACK_EMPTY) begin
			stack_fill <= stack_fill - 3'h1;
		end
	end

	// Empty pop gives no address; the core just falls through
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ret_valid <= 1'b0;
			ret_addr  <= '0;
		end else begin
			ret_valid <= pop && stack_fill != STACK_EMPTY;
			ret_addr  <= stack_mem[0];
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_nmi_vector;
		@(posedge sys_clk) disable iff (srst)
		take_nmi |=> irq_take && vector_addr == 12'hffc;
	endproperty
	a_nmi_vector: assert property (p_nmi_vector)
		else $error("non-maskable entry without its vector");

	property p_porta_vector;
		@(posedge sys_clk) disable iff (srst)
		take_mask && req[0] |=> vector_addr == 12'hff6;
	endproperty
	a_porta_vector: assert property (p_porta_vector)
		else $error("port A request lost priority");

	property p_timer_vector;
		@(posedge sys_clk) disable iff (srst)
		take_mask && req[2:0] == 3'b100 |=> vector_addr == 12'hff2;
	endproperty
	a_timer_vector: assert property (p_timer_vector)
		else $error("timer request got the wrong vector");

	property p_mask_gate;
		@(posedge sys_clk) disable iff (srst)
		irq_take && flag_mode == MODE_IRQ |->
			$past(option_view[GLB_EN_BIT]) && $past(mode) == MODE_NORMAL;
	endproperty
	a_mask_gate: assert property (p_mask_gate)
		else $error("maskable entry while disabled or nested");

	property p_no_nesting;
		@(posedge sys_clk) disable iff (srst)
		flag_mode == MODE_IRQ && !return_from_irq && !nmi_latch
			|=> flag_mode == MODE_IRQ;
	endproperty
	a_no_nesting: assert property (p_no_nesting)
		else $error("maskable routine left without return");

	property p_nmi_clear;
		@(posedge sys_clk) disable iff (srst)
		take_nmi && !nmi_fall |=> !nmi_latch && flag_mode == MODE_NMI;
	endproperty
	a_nmi_clear: assert property (p_nmi_clear)
		else $error("non-maskable latch not cleared on entry");

	property p_reset_mode;
		@(posedge sys_clk)
		srst |=> flag_mode == MODE_NMI && option_view == 8'h00;
	endproperty
	a_reset_mode: assert property (p_reset_mode)
		else $error("reset did not enter non-maskable mode");

	property p_level_nostore;
		@(posedge sys_clk) disable iff (srst)
		level_mode |=> !pa_latch;
	endproperty
	a_level_nostore: assert property (p_level_nostore)
		else $error("level mode stored a request");

	property p_stack_push;
		@(posedge sys_clk) disable iff (srst)
		push |=> stack_mem[0] == $past(next_pc) && stack_fill != 3'h0;
	endproperty
	a_stack_push: assert property (p_stack_push)
		else $error("entry did not push the program counter");

	property p_only_boundary;
		@(posedge sys_clk) disable iff (srst)
		irq_take |-> $past(instr_end);
	endproperty
	a_only_boundary: assert property (p_only_boundary)
		else $error("entry outside an instruction boundary");

	property p_write_only_byte;
		@(posedge sys_clk) disable iff (srst)
		ds_wr && ds_bitop |=> $stable(option_view);
	endproperty
	a_write_only_byte: assert property (p_write_only_byte)
		else $error("single-bit write changed the option register");

endmodule

// >>> bench/viu_core_model.sv
// Behavioural core sequencer facing the interrupt unit
`timescale 1ns/1ns

module viu_core_model
	import viu_pkg::*;
(
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    srst,
	// Pace select, slow gives five-cycle instructions
	input  wire logic                    slow,
	// Answers from the unit
	input  wire logic                    irq_take,
	input  wire logic [viu_pkg::PC_W-1:0] vector_addr,
	// Sequencing towards the unit
	output logic                         instr_end,
	output logic [viu_pkg::PC_W-1:0]     next_pc,
	output int                           take_cnt
);
	int                cnt;
	int                done;
	logic [PC_W-1:0]   last_vec;
	logic              srst_q;
	logic              slow_q;

	// Bench inputs move on the falling edge; resample to avoid a race
	always @(posedge sys_clk) begin
		srst_q <= srst;
		slow_q <= slow;
	end

	// Count accepted entries; sampled on the unit's own edge
	always @(posedge sys_clk) begin
		if (srst) begin
			take_cnt <= 0;
		end else if (irq_take === 1'b1) begin
			take_cnt <= take_cnt + 1;
			last_vec <= vector_addr;
		end
	end

	// Driven off the falling edge so the unit never sees a race
	always @(negedge sys_clk) begin
		if (srst_q) begin
			cnt       <= 0;
			done      <= 0;
			instr_end <= 1'b0;
			next_pc   <= 12'h080;
		end else begin
			instr_end <= (cnt == 0);
			cnt       <= (cnt == 0) ? (slow_q ? 4 : 1) : cnt - 1;
			if (done != take_cnt) begin
				done    <= take_cnt;
				next_pc <= last_vec;
			end else if (cnt == 0) begin
				next_pc <= next_pc + 12'h001;
			end
		end
	end

endmodule

// >>> bench/tb_vectored_interrupt_unit.sv
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/1ns
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin \
	err_count++; $display("MISMATCH %0t %s", $time, m); end end

module tb_vectored_interrupt_unit;
	import viu_pkg::*;

	logic sys_clk, srst, ds_wr, ds_bitop, nmi_pin_n, porta_irq_n;
	logic portbc_irq, timer_zero_flag, timer_irq_mask, slow;
	logic converter_done_flag, converter_irq_mask, instr_end;
	logic return_from_irq, sub_call, sub_return, irq_take, ret_valid;
	logic [7:0] ds_addr, ds_wdata, option_view, d, a, prev;
	logic [11:0] next_pc, vector_addr, ret_addr;
	logic [11:0] pcs [7];
	logic [11:0] vecs [4];
	viu_mode_t flag_mode;
	int err_count, compares, cycles, take_cnt;

	viu_core i_dut (.sys_clk(sys_clk), .srst(srst), .ds_addr(ds_addr),
		.ds_wdata(ds_wdata), .ds_wr(ds_wr), .ds_bitop(ds_bitop),
		.nmi_pin_n(nmi_pin_n), .porta_irq_n(porta_irq_n),
		.portbc_irq(portbc_irq), .timer_zero_flag(timer_zero_flag),
		.timer_irq_mask(timer_irq_mask),
		.converter_done_flag(converter_done_flag),
		.converter_irq_mask(converter_irq_mask), .instr_end(instr_end),
		.return_from_irq(return_from_irq), .sub_call(sub_call),
		.sub_return(sub_return), .next_pc(next_pc), .irq_take(irq_take),
		.vector_addr(vector_addr), .ret_valid(ret_valid),
		.ret_addr(ret_addr), .flag_mode(flag_mode),
		.option_view(option_view));

	viu_core_model i_core (.sys_clk(sys_clk), .srst(srst), .slow(slow),
		.irq_take(irq_take), .vector_addr(vector_addr),
		.instr_end(instr_end), .next_pc(next_pc), .take_cnt(take_cnt));

	// Clock, 20 ns period
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Hang guard, well above the few hundred cycles needed
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			close_out();
		end
	end

	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic rst();
		srst = 1'b1;
		tick(10);
		srst = 1'b0;
		`CHK(vector_addr, VEC0_NMI, "reset vector")
		`CHK(flag_mode, MODE_NMI, "reset mode")
		`CHK(option_view, OPT_RESET, "reset option")
	endtask

	task automatic wr(input logic [7:0] ad, dt, input logic b);
		ds_addr  = ad;
		ds_wdata = dt;
		ds_bitop = b;
		ds_wr    = 1'b1;
		tick(1);
		ds_wr    = 1'b0;
		tick(1);
	endtask

	task automatic ret();
		return_from_irq = 1'b1;
		tick(1);
		return_from_irq = 1'b0;
	endtask

	// Bounded wait for one entry, then its vector
	task automatic take(input logic [11:0] v);
		int c;
		c = take_cnt;
		for (int i = 0; i < 40 && take_cnt == c; i++)
			tick(1);
		`CHK(take_cnt, c + 1, "entry count")
		`CHK(vector_addr, v, "vector")
	endtask

	task automatic none(input int n);
		int c;
		c = take_cnt;
		tick(n);
		`CHK(take_cnt, c, "unexpected entry")
	endtask

	// Short low pulse, long enough for the pin synchroniser
	task automatic edge_a();
		porta_irq_n = 1'b0;
		tick(3);
		porta_irq_n = 1'b1;
		tick(3);
	endtask

	initial begin
		{ds_wr, ds_bitop, slow, return_from_irq} = '0;
		{sub_call, sub_return, timer_zero_flag, timer_irq_mask} = '0;
		{converter_done_flag, converter_irq_mask, ds_addr, ds_wdata} = '0;
		{nmi_pin_n, porta_irq_n, portbc_irq, srst} = '1;
		vecs = '{VEC1_PORTA, VEC2_PORTBC, VEC3_TIMER, VEC4_ADC};
		void'($urandom(32'h818b6eff));
		rst();
		ret();
		`CHK(ret_valid, 1'b0, "empty pop")
		`CHK(flag_mode, MODE_NORMAL, "leave start mode")
		$display("test reset done");
		// All four maskables pending, global enable still off
		slow = 1'b1;
		{timer_zero_flag, timer_irq_mask} = 2'b11;
		{converter_done_flag, converter_irq_mask} = 2'b11;
		edge_a();
		portbc_irq = 1'b0;
		tick(3);
		portbc_irq = 1'b1;
		none(20);
		wr(OPT_ADDR, 8'h10, 1'b0);
		foreach (vecs[i]) begin
			take(vecs[i]);
			timer_zero_flag     = timer_zero_flag & (i != 2);
			converter_done_flag = converter_done_flag & (i != 3);
			none(12);
			ret();
		end
		none(12);
		$display("test priority done");
		timer_irq_mask  = 1'b0;
		timer_zero_flag = 1'b1;
		none(12);
		timer_irq_mask = 1'b1;
		take(VEC3_TIMER);
		timer_zero_flag = 1'b0;
		nmi_pin_n = 1'b0;
		tick(3);
		nmi_pin_n = 1'b1;
		take(VEC0_NMI);
		`CHK(flag_mode, MODE_NMI, "nmi flags")
		ret();
		`CHK(flag_mode, MODE_IRQ, "restored flags")
		none(12);
		edge_a();
		edge_a();
		ret();
		take(VEC1_PORTA);
		ret();
		none(12);
		$display("test nmi and edge done");
		wr(OPT_ADDR, 8'h50, 1'b0);
		timer_zero_flag = 1'b1;
		take(VEC3_TIMER);
		timer_zero_flag = 1'b0;
		edge_a();
		ret();
		none(12);
		porta_irq_n = 1'b0;
		take(VEC1_PORTA);
		porta_irq_n = 1'b1;
		tick(4);
		ret();
		wr(OPT_ADDR, 8'h30, 1'b0);
		portbc_irq = 1'b0;
		none(12);
		portbc_irq = 1'b1;
		take(VEC2_PORTBC);
		ret();
		$display("test modes done");
		prev = 8'h30;
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			a = 8'($urandom);
			if (a == OPT_ADDR)
				a = ~a;
			wr(OPT_ADDR, d, 1'b1);
			`CHK(option_view, prev, "bit op")
			wr(a, ~d, 1'b0);
			`CHK(option_view, prev, "other address")
			wr(OPT_ADDR, d, 1'b0);
			`CHK(option_view, d, "option write")
			prev = d;
		end
		$display("test option done");
		wr(OPT_ADDR, 8'h00, 1'b0);
		for (int i = 0; i < 7; i++) begin
			sub_call = 1'b1;
			@(posedge sys_clk) pcs[i] = next_pc;
			tick(1);
			sub_call = 1'b0;
			tick($urandom_range(1, 3));
		end
		for (int i = 0; i < 7; i++) begin
			sub_return = 1'b1;
			tick(1);
			sub_return = 1'b0;
			`CHK(ret_valid, i < 6, "pop valid")
			if (i < 6)
				`CHK(ret_addr, pcs[6 - i], "pop address")
			tick(1);
		end
		$display("test stack done");
		wr(OPT_ADDR, 8'h70, 1'b0);
		rst();
		$display("test second reset done");
		close_out();
	end

endmodule
